// [src/idc_ctx_ctrl.sv]
// isochronous DMA context control, status and receive packet formatter
//
// Functional notes
// - tx context active flag at bit 10 stays one while descriptors are processed
// - control bits 9 to 8 always read as zero
// - speed field bits 7 to 5 has no meaning for transmit, reads zero
// - after last output command, the outcome is kept in event bits 4 to 0
// - read-only command pointer loads each descriptor fetched while run is set and active is clear
// - eight transmit contexts, command pointers at a 16-byte stride
// - four receive contexts, each with its own control register
// - receive control at set address, clear address four above, 32-byte stride
// - pack_buffers set packs packets back to back, clear gives one buffer each
// - keep_packet_header stores the whole 4-byte header with each packet
// - with header kept, packet ends with transfer_status then 16-bit cycle_stamp
// - with keep_packet_header clear, header is dropped, payload only stored
// - a kept header sits directly ahead of its payload, no gap
// - run is set and cleared by software only, hardware changes it on reset
// - multi_channel_receive takes mask-enabled channels, ignores own channel match
`timescale 1ns/1ps
module idc_ctx_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regRdValid,
  // descriptor engine
  input wire logic engFetch,
  input wire logic engDone,
  input wire logic engIdle,
  input wire logic engDead,
  input wire logic engIsRx,
  input wire logic [2:0] engCtx,
  input wire logic [31:0] engAddr,
  input wire logic [1:0] engOutcome,
  output logic [7:0] txRun,
  output logic [7:0] txWake,
  output logic [7:0] txActive,
  output logic [3:0] rxRun,
  output logic [3:0] rxWake,
  output logic [3:0] rxActive,
  output logic [3:0] rxMultiChannel,
  // cycle timer
  input wire logic cycleStart,
  input wire logic [15:0] cycleCount,
  // received packet stream
  input wire logic pktValid,
  output logic pktReady,
  input wire logic [31:0] pktData,
  input wire logic pktFirst,
  input wire logic pktLast,
  input wire logic [1:0] pktCtx,
  input wire logic pktChanMatch,
  input wire logic pktMaskHit,
  input wire logic [15:0] pktStatus,
  // buffer write stream
  output logic memValid,
  input wire logic memReady,
  output logic [31:0] memData,
  output logic [1:0] memCtx,
  output logic memBufEnd
);
  localparam int NC = idc_pkg::NUM_CTX;
  localparam int NT = idc_pkg::NUM_TX;
  localparam int NR = idc_pkg::NUM_RX;

  // ---------------------------------------------------------------
  // context state
  // ---------------------------------------------------------------
  logic [NC-1:0] run_q;
  logic [NC-1:0] wake_q;
  logic [NC-1:0] dead_q;
  logic [NC-1:0] active_q;
  logic [4:0] evt_q [NC];
  logic [31:0] ptr_q [NC];
  logic [NR-1:0] pack_q;
  logic [NR-1:0] keep_q;
  logic [NR-1:0] multi_q;
  wire [NC-1:0] run_d;
  wire [NC-1:0] wake_d;
  wire [NC-1:0] dead_d;
  wire [NC-1:0] active_d;
  wire [4:0] evt_d [NC];
  wire [31:0] ptr_d [NC];
  wire [NR-1:0] pack_d;
  wire [NR-1:0] keep_d;
  wire [NR-1:0] multi_d;
  wire [NC-1:0] setHit;
  wire [NC-1:0] clrHit;
  wire [NC-1:0] ctlRdHit;
  wire [31:0] rdWord [NC];
  logic [31:0] rdMux;
  logic [31:0] regRdData_q;
  logic regRdValid_q;
  logic rdCtl_q;

  function automatic logic setClr(input logic cur, input logic s, input logic c);
    return (cur | s) & ~c;
  endfunction

  // ---------------------------------------------------------------
  // engine event decode
  // ---------------------------------------------------------------
  wire [3:0] engSel = engIsRx ? 4'(engCtx[1:0]) + 4'(NT) : {1'b0, engCtx};
  wire [4:0] evtCode =
    engOutcome == idc_pkg::IDC_OUT_ACK ? idc_pkg::EVT_ACK_COMPLETE :
    engOutcome == idc_pkg::IDC_OUT_DESC ? idc_pkg::EVT_DESCRIPTOR_READ :
    engOutcome == idc_pkg::IDC_OUT_DATA ? idc_pkg::EVT_DATA_READ : idc_pkg::EVT_UNKNOWN;
  wire [NC-1:0] packAll = {pack_q, 8'h00};
  wire [NC-1:0] keepAll = {keep_q, 8'h00};
  wire [NC-1:0] multiAll = {multi_q, 8'h00};

  // ---------------------------------------------------------------
  // per-context control, status and pointer
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NC; i++) begin : g_ctx
    localparam bit IS_RX = i >= NT;
    localparam int RXN = IS_RX ? i - NT : 0;
    localparam logic [11:0] SET_ADR = IS_RX ?
      12'(int'(idc_pkg::RX_CTL_SET_OFS) + RXN * idc_pkg::RX_STRIDE) :
      12'(int'(idc_pkg::TX_CTL_SET_OFS) + i * idc_pkg::TX_STRIDE);
    localparam logic [11:0] CLR_ADR = IS_RX ?
      12'(int'(idc_pkg::RX_CTL_CLR_OFS) + RXN * idc_pkg::RX_STRIDE) :
      12'(int'(idc_pkg::TX_CTL_CLR_OFS) + i * idc_pkg::TX_STRIDE);
    localparam logic [11:0] PTR_ADR =
      12'(int'(idc_pkg::TX_CMD_PTR_OFS) + i * idc_pkg::TX_STRIDE);
    wire engHit = engSel == 4'(i);
    wire fetchHit = engFetch && engHit;
    wire doneHit = engDone && engHit;
    wire idleHit = engIdle && engHit;
    wire deadHit = engDead && engHit;
    wire runFall = run_q[i] && !run_d[i];
    wire ptrRdHit = !IS_RX && regAddr == PTR_ADR;
    wire [31:0] ctlWord;

    assign setHit[i] = regWr && regAddr == SET_ADR;
    assign clrHit[i] = regWr && regAddr == CLR_ADR;
    assign ctlRdHit[i] = regAddr == SET_ADR || regAddr == CLR_ADR;
    // only software moves run; reset is the sole hardware path
    assign run_d[i] = setClr(run_q[i], setHit[i] && regWrData[idc_pkg::RUN_BIT],
      clrHit[i] && regWrData[idc_pkg::RUN_BIT]);
    // software set wins over the fetch clear
    assign wake_d[i] = (setHit[i] && regWrData[idc_pkg::WAKE_BIT]) || (wake_q[i] && !fetchHit);
    assign dead_d[i] = deadHit || (dead_q[i] && !runFall);
    assign active_d[i] = run_d[i] && !deadHit &&
      ((fetchHit && !dead_q[i]) || (active_q[i] && !idleHit));
    assign evt_d[i] = doneHit ? evtCode : evt_q[i];
    assign ptr_d[i] = (fetchHit && run_q[i] && !active_q[i]) ? engAddr : ptr_q[i];
    // reserved and speed bits are constant zero
    assign ctlWord = {packAll[i], keepAll[i], 1'b0, multiAll[i], 12'h000,
      run_q[i], 2'b00, wake_q[i], dead_q[i], active_q[i], 2'b00, 3'b000,
      evt_q[i]};
    assign rdWord[i] = ctlRdHit[i] ? ctlWord : ptrRdHit ? ptr_q[i] : 32'h00000000;
  end

  for (genvar j = 0; j < NR; j++) begin : g_rxopt
    localparam int C = NT + j;
    wire s = setHit[C];
    wire c = clrHit[C];
    assign pack_d[j] = setClr(pack_q[j], s && regWrData[idc_pkg::PACK_BIT],
      c && regWrData[idc_pkg::PACK_BIT]);
    assign keep_d[j] = setClr(keep_q[j], s && regWrData[idc_pkg::KEEP_BIT],
      c && regWrData[idc_pkg::KEEP_BIT]);
    assign multi_d[j] = setClr(multi_q[j], s && regWrData[idc_pkg::MULTI_BIT],
      c && regWrData[idc_pkg::MULTI_BIT]);
  end

  always_comb begin
    rdMux = 32'h00000000;
    for (int k = 0; k < NC; k++) begin
      rdMux = rdMux | rdWord[k];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= '0;
      wake_q <= '0;
      dead_q <= '0;
      active_q <= '0;
      pack_q <= '0;
      keep_q <= '0;
      multi_q <= '0;
      for (int k = 0; k < NC; k++) begin
        evt_q[k] <= idc_pkg::EVT_RESET;
        ptr_q[k] <= idc_pkg::PTR_RESET;
      end
    end else if (ce) begin
      run_q <= run_d;
      wake_q <= wake_d;
      dead_q <= dead_d;
      active_q <= active_d;
      pack_q <= pack_d;
      keep_q <= keep_d;
      multi_q <= multi_d;
      for (int k = 0; k < NC; k++) begin
        evt_q[k] <= evt_d[k];
        ptr_q[k] <= ptr_d[k];
      end
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData_q <= 32'h00000000;
      regRdValid_q <= 1'b0;
      rdCtl_q <= 1'b0;
    end else if (ce) begin
      regRdValid_q <= regRd;
      rdCtl_q <= regRd && |ctlRdHit;
      if (regRd) begin
        regRdData_q <= rdMux;
      end
    end
  end

  assign regRdData = regRdData_q;
  assign regRdValid = regRdValid_q;
  assign txRun = run_q[NT-1:0];
  assign txWake = wake_q[NT-1:0];
  assign txActive = active_q[NT-1:0];
  assign rxRun = run_q[NC-1:NT];
  assign rxWake = wake_q[NC-1:NT];
  assign rxActive = active_q[NC-1:NT];
  assign rxMultiChannel = multi_q;

  // ---------------------------------------------------------------
  // receive packet formatter
  // ---------------------------------------------------------------
  idc_pkg::idc_fmt_e state_q;
  idc_pkg::idc_fmt_e state_d;
  logic [1:0] curCtx_q;
  logic curKeep_q;
  logic curPack_q;
  logic [15:0] status_q;
  logic [15:0] stamp_q;
  idc_stream_if #(.W(idc_pkg::FIFO_W)) fmtIf ();
  idc_stream_if #(.W(idc_pkg::FIFO_W)) memIf ();

  wire inIdle = state_q == idc_pkg::FMT_IDLE;
  wire inBody = state_q == idc_pkg::FMT_BODY;
  wire inTrail = state_q == idc_pkg::FMT_TRAIL;
  wire inDrop = state_q == idc_pkg::FMT_DROP;
  wire [1:0] ctxNow = inIdle ? pktCtx : curCtx_q;
  wire keepNow = inIdle ? keep_q[pktCtx] : curKeep_q;
  wire packNow = inIdle ? pack_q[pktCtx] : curPack_q;
  // multi-channel follows the mask, else the own channel match
  wire acceptPkt = rxRun[pktCtx] &&
    (multi_q[pktCtx] ? pktMaskHit : pktChanMatch);
  wire hdrEmit = inIdle && pktValid && pktFirst && acceptPkt && keepNow;
  wire fmtWant = hdrEmit || (inBody && pktValid) || inTrail;
  // unpacked payload-only packet closes its buffer on the last payload word
  wire bufEnd = !packNow &&
    (inTrail || (inBody && pktLast && !keepNow));
  wire [31:0] fmtWord = inTrail ? {status_q, stamp_q} : pktData;
  wire take = pktValid && pktReady;

  assign fmtIf.valid = ce && fmtWant;
  assign fmtIf.data = {ctxNow, bufEnd, fmtWord};
  assign pktReady = ce && !inTrail && ((inBody || hdrEmit) ? fmtIf.ready : 1'b1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      idc_pkg::FMT_IDLE: begin
        if (take && pktFirst) begin
          if (!acceptPkt) begin
            state_d = pktLast ? idc_pkg::FMT_IDLE : idc_pkg::FMT_DROP;
          end else if (pktLast) begin
            state_d = keepNow ? idc_pkg::FMT_TRAIL : idc_pkg::FMT_IDLE;
          end else begin
            state_d = idc_pkg::FMT_BODY;
          end
        end
      end
      idc_pkg::FMT_BODY: begin
        if (take && pktLast) begin
          state_d = curKeep_q ? idc_pkg::FMT_TRAIL : idc_pkg::FMT_IDLE;
        end
      end
      idc_pkg::FMT_TRAIL: begin
        if (fmtIf.ready) begin
          state_d = idc_pkg::FMT_IDLE;
        end
      end
      idc_pkg::FMT_DROP: begin
        if (take && pktLast) begin
          state_d = idc_pkg::FMT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= idc_pkg::FMT_IDLE;
      curCtx_q <= 2'h0;
      curKeep_q <= 1'b0;
      curPack_q <= 1'b0;
      status_q <= 16'h0000;
      stamp_q <= idc_pkg::STAMP_RESET;
    end else if (ce) begin
      state_q <= state_d;
      if (inIdle && take && pktFirst) begin
        curCtx_q <= pktCtx;
        curKeep_q <= keep_q[pktCtx];
        curPack_q <= pack_q[pktCtx];
      end
      if (take && pktLast) begin
        status_q <= pktStatus;
      end
      if (cycleStart) begin
        stamp_q <= cycleCount;
      end
    end
  end

  idc_fifo #(.WIDTH(idc_pkg::FIFO_W), .DEPTH(idc_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .wr(fmtIf),
    .rd(memIf)
  );

  assign memValid = memIf.valid;
  assign memIf.ready = memReady;
  assign memData = memIf.data[idc_pkg::WORD_W-1:0];
  assign memBufEnd = memIf.data[idc_pkg::BUF_END_POS];
  assign memCtx = memIf.data[idc_pkg::CTX_LSB +: idc_pkg::CTX_W];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_active_needs_run: assert property ((active_q & ~run_q) == '0)
    else $error("active set without run");
  a_rsvd_read_zero: assert property (regRdValid && rdCtl_q |-> regRdData[9:5] == 5'h00)
    else $error("reserved or speed bits nonzero");
  a_evt_ack_record: assert property (ce && engDone && engSel == 4'h3 &&
    engOutcome == idc_pkg::IDC_OUT_ACK |=> evt_q[3] == idc_pkg::EVT_ACK_COMPLETE)
    else $error("event code not recorded");
  a_ptr_first_fetch: assert property (ce && engFetch && engSel == 4'h3 && run_q[3] &&
    !active_q[3] && !dead_q[3] && run_d[3] |=> ptr_q[3] == $past(engAddr) && txActive[3])
    else $error("first descriptor pointer not held");
  a_ptr_read_stride: assert property (ce && regRd && !engFetch &&
    regAddr == 12'(int'(idc_pkg::TX_CMD_PTR_OFS) + 7 * idc_pkg::TX_STRIDE)
    |=> regRdValid && regRdData == ptr_q[7])
    else $error("command pointer read mismatch");
  a_rx_set_clear: assert property (ce && regWr && regWrData[idc_pkg::PACK_BIT] &&
    regAddr == 12'(int'(idc_pkg::RX_CTL_CLR_OFS) + 3 * idc_pkg::RX_STRIDE) |=> !pack_q[3])
    else $error("clear address did not clear");
  a_buf_end_pack: assert property (fmtIf.valid && fmtIf.data[idc_pkg::BUF_END_POS]
    |-> !packNow)
    else $error("buffer end while packing");
  a_hdr_then_body: assert property (ce && hdrEmit && fmtIf.ready && !pktLast
    |-> fmtIf.data[31:0] == pktData ##1 inBody)
    else $error("header not ahead of payload");
  a_hdr_dropped: assert property (inIdle && pktValid && pktFirst && !keep_q[pktCtx]
    |-> !fmtIf.valid)
    else $error("header stored while stripping");
  a_trailer_word: assert property (ce && inBody && take && pktLast && curKeep_q
    |=> fmtIf.valid && fmtIf.data[31:16] == $past(pktStatus))
    else $error("trailer missing after packet");
  a_run_sw_only: assert property (!(ce && regWr) |=> run_q == $past(run_q))
    else $error("run changed without a write");
  a_multi_mask: assert property (ce && inIdle && take && pktFirst && !pktLast &&
    rxRun[pktCtx] && multi_q[pktCtx] && !pktMaskHit |=> inDrop)
    else $error("masked channel not ignored");

  c_tx_goes_active: cover property (ce && engFetch && txActive == 8'h00 ##1 txActive != 8'h00);
  c_trailer_sent: cover property (inTrail && fmtIf.ready && ce);
  c_packet_dropped: cover property (inDrop);
  c_fifo_full: cover property (fmtWant && !fmtIf.ready);

endmodule

// [src/idc_pkg.sv]
// shared constants and types for the isochronous context control block
package idc_pkg;

  // ---------------------------------------------------------------
  // context counts and widths
  // ---------------------------------------------------------------
  localparam int NUM_TX = 8;
  localparam int NUM_RX = 4;
  localparam int NUM_CTX = NUM_TX + NUM_RX;
  localparam int WORD_W = 32;
  localparam int CTX_W = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = WORD_W + 1 + CTX_W;
  localparam int BUF_END_POS = WORD_W;
  localparam int CTX_LSB = WORD_W + 1;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] TX_CTL_SET_OFS = 12'h200;
  localparam logic [11:0] TX_CTL_CLR_OFS = 12'h204;
  localparam logic [11:0] TX_CMD_PTR_OFS = 12'h20C;
  localparam int TX_STRIDE = 16;
  localparam logic [11:0] RX_CTL_SET_OFS = 12'h400;
  localparam logic [11:0] RX_CTL_CLR_OFS = 12'h404;
  localparam int RX_STRIDE = 32;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int PACK_BIT = 31;
  localparam int KEEP_BIT = 30;
  localparam int MULTI_BIT = 28;
  localparam int RUN_BIT = 15;
  localparam int WAKE_BIT = 12;
  localparam int DEAD_BIT = 11;
  localparam int ACTIVE_BIT = 10;
  localparam int EVT_W = 5;

  // ---------------------------------------------------------------
  // reset values and event encodings
  // ---------------------------------------------------------------
  localparam logic [4:0] EVT_RESET = 5'h00;
  localparam logic [4:0] EVT_ACK_COMPLETE = 5'h11;
  localparam logic [4:0] EVT_DESCRIPTOR_READ = 5'h06;
  localparam logic [4:0] EVT_DATA_READ = 5'h07;
  localparam logic [4:0] EVT_UNKNOWN = 5'h0E;
  localparam logic [31:0] PTR_RESET = 32'h00000000;
  localparam logic [15:0] STAMP_RESET = 16'h0000;

  typedef enum logic [1:0] {
    IDC_OUT_ACK = 2'b00,
    IDC_OUT_DESC = 2'b01,
    IDC_OUT_DATA = 2'b10,
    IDC_OUT_UNKNOWN = 2'b11
  } idc_outcome_e;

  typedef enum logic [1:0] {
    FMT_IDLE = 2'b00,
    FMT_BODY = 2'b01,
    FMT_TRAIL = 2'b11,
    FMT_DROP = 2'b10
  } idc_fmt_e;

endpackage

// [src/idc_stream_if.sv]
// valid/ready word stream between the formatter and the buffer
`timescale 1ns/1ps
interface idc_stream_if #(parameter int W = 35) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [src/idc_fifo.sv]
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module idc_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // streams
  idc_stream_if.snk wr,
  idc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;

  wire full = count_q == (AW+1)'(DEPTH);
  wire empty = count_q == '0;
  wire push = ce && wr.valid && !full;
  wire pop = ce && rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem_q[rdPtr_q];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_q[k] <= '0;
      end
    end else begin
      if (push) begin
        mem_q[wrPtr_q] <= wr.data;
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_fifo_count_bound: assert property (count_q <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");

endmodule

// [test/idc_mem_sink.sv]
// far-side buffer memory model that records every formatted word
`timescale 1ns/1ps
module idc_mem_sink (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // buffer write stream
  input wire logic memValid,
  output logic memReady,
  input wire logic [31:0] memData,
  input wire logic [1:0] memCtx,
  input wire logic memBufEnd,
  // pacing: hold stalls fully, slow accepts every other cycle
  input wire logic hold,
  input wire logic slow
);
  logic take;
  logic [34:0] word;
  logic [34:0] got[$];

  // ---------------------------------------------------------------
  // capture and pacing
  // ---------------------------------------------------------------
  // sample settled values mid-cycle, commit at the edge
  always @(negedge clk) begin
    take = memValid && memReady;
    word = {memBufEnd, memCtx, memData};
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memReady <= 1'b0;
    end else begin
      if (take) begin
        got.push_back(word);
      end
      memReady <= !hold && !(slow && memReady);
    end
  end
endmodule

// [test/tb_top.sv]
// self-checking bench for the isochronous context control block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, rdyS = 1'b0;
  logic engFetch = 1'b0, engDone = 1'b0, engIdle = 1'b0, cycleStart = 1'b0;
  logic pktValid = 1'b0, pktFirst = 1'b0, pktLast = 1'b0, pktChanMatch = 1'b0;
  logic pktMaskHit = 1'b0, hold = 1'b0, slow = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h00000000, engAddr = 32'h00000000, pktData = 32'h00000000;
  logic [2:0] engCtx = 3'h0;
  logic [1:0] engOutcome = 2'h0, pktCtx = 2'h0, memCtx;
  logic [15:0] cycleCount = 16'h0000, pktStatus = 16'h0000;
  logic [31:0] regRdData, memData;
  logic regRdValid, pktReady, memValid, memReady, memBufEnd;
  logic [7:0] txRun, txActive;
  logic [3:0] rxMultiChannel;
  logic [4:0] evtTab [4] = '{idc_pkg::EVT_ACK_COMPLETE, idc_pkg::EVT_DESCRIPTOR_READ,
                             idc_pkg::EVT_DATA_READ, idc_pkg::EVT_UNKNOWN};
  int bad_count = 0, check_count = 0, cyc = 0;

  idc_ctx_ctrl u_idc_ctx_ctrl (
    .clk(clk), .nrst(nrst), .ce(1'b1), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .engFetch(engFetch), .engDone(engDone), .engIdle(engIdle), .engDead(1'b0),
    .engIsRx(1'b0), .engCtx(engCtx), .engAddr(engAddr), .engOutcome(engOutcome),
    .txRun(txRun), .txWake(), .txActive(txActive), .rxRun(), .rxWake(), .rxActive(),
    .rxMultiChannel(rxMultiChannel), .cycleStart(cycleStart), .cycleCount(cycleCount),
    .pktValid(pktValid), .pktReady(pktReady), .pktData(pktData), .pktFirst(pktFirst),
    .pktLast(pktLast), .pktCtx(pktCtx), .pktChanMatch(pktChanMatch),
    .pktMaskHit(pktMaskHit), .pktStatus(pktStatus), .memValid(memValid),
    .memReady(memReady), .memData(memData), .memCtx(memCtx), .memBufEnd(memBufEnd)
  );

  idc_mem_sink u_idc_mem_sink (
    .clk(clk), .nrst(nrst), .memValid(memValid), .memReady(memReady), .memData(memData),
    .memCtx(memCtx), .memBufEnd(memBufEnd), .hold(hold), .slow(slow)
  );

  always #10 clk = ~clk;
  always @(negedge clk) rdyS = pktReady;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk({3'h0, regRdValid, regRdData}, {3'h0, 1'b1, e}, m);
  endtask

  task automatic eng(input int k, input logic [31:0] a, input logic [1:0] o);
    @(posedge clk);
    engCtx <= 3'h3;
    engAddr <= a;
    engOutcome <= o;
    engFetch <= (k == 0);
    engDone <= (k == 1);
    engIdle <= (k == 2);
    @(posedge clk);
    engFetch <= 1'b0;
    engDone <= 1'b0;
    engIdle <= 1'b0;
  endtask

  // options change only with run clear, pack, keep and multi cleared first
  task automatic opt(input logic [31:0] o);
    wr(12'h424, 32'h00008000);
    wr(12'h424, 32'hD0000000);
    wr(12'h420, o);
    wr(12'h420, 32'h00008000);
  endtask

  task automatic pkt(input int n, input logic [15:0] s);
    int k;
    @(posedge clk);
    for (int i = 0; i <= n; i++) begin
      pktValid <= 1'b1;
      pktCtx <= 2'h1;
      pktData <= 32'hA0000000 + i;
      pktFirst <= (i == 0);
      pktLast <= (i == n);
      pktStatus <= s;
      k = 0;
      @(posedge clk);
      while (rdyS !== 1'b1 && k < 60) begin
        k++;
        @(posedge clk);
      end
    end
    pktValid <= 1'b0;
  endtask

  task automatic expect_pkt(input int n, input logic [15:0] s, input logic keep,
                            input logic pack);
    logic [31:0] d;
    for (int t = 0; t < 80 && u_idc_mem_sink.got.size() < (keep ? n + 2 : n); t++) begin
      @(posedge clk);
    end
    for (int i = keep ? 0 : 1; i <= n + keep; i++) begin
      d = (i > n) ? {s, 16'h1234} : 32'hA0000000 + i;
      chk({1'b0, u_idc_mem_sink.got.pop_front()}, {1'b0, !pack && i == n + keep, 2'h1, d},
          "buffer word");
    end
    chk({4'h0, 32'(u_idc_mem_sink.got.size())}, 36'h0, "extra words");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(idc_pkg::TX_CTL_SET_OFS, 32'h00000000, "tx reset");
    wr(12'h230, 32'hFFFFFFFF);
    rd(12'h234, 32'h00009000, "tx set bits");
    eng(0, 32'h12345670, 2'h0);
    eng(0, 32'h0000ABC0, 2'h0);
    wr(12'h23C, 32'hFFFFFFFF);
    rd(12'h23C, 32'h12345670, "pointer");
    rd(12'h27C, 32'h00000000, "pointer 7");
    rd(12'h230, 32'h00008400, "active flag");
    chk({28'h0, txActive}, 36'h8, "active out");
    for (int i = 0; i < 4; i++) begin
      eng(1, 32'h00000000, i[1:0]);
      rd(12'h230, {27'h0000420, evtTab[i]}, "event");
    end
    eng(2, 32'h00000000, 2'h0);
    rd(12'h230, {27'h0000400, evtTab[3]}, "idle");
    wr(12'h234, 32'h00008000);
    eng(0, 32'h00000000, 2'h0);
    rd(12'h230, {27'h0000000, evtTab[3]}, "fetch without run");
    for (int n = 0; n < 8; n++) begin
      wr(12'h200 + 12'(16 * n), 32'h00008000);
      rd(12'h204 + 12'(16 * n), {27'h0000400, n == 3 ? evtTab[3] : 5'h00}, "tx run");
      chk({28'h0, txRun}, {28'h0, 8'h01 << n}, "run out");
      wr(12'h204 + 12'(16 * n), 32'h00008000);
    end
    for (int n = 0; n < 4; n++) begin
      wr(12'h400 + 12'(32 * n), 32'hFFFF7FFF);
      rd(12'h404 + 12'(32 * n), 32'hD0001000, "rx options");
      chk({32'h0, rxMultiChannel}, {32'h0, 4'h1 << n}, "multi out");
      wr(12'h404 + 12'(32 * n), 32'hD0000000);
      rd(12'h400 + 12'(32 * n), 32'h00001000, "rx clear");
    end
    rd(12'h480, 32'h00000000, "unmapped");
    @(posedge clk);
    cycleStart <= 1'b1;
    cycleCount <= 16'h1234;
    pktChanMatch <= 1'b1;
    @(posedge clk);
    cycleStart <= 1'b0;
    opt(32'h40000000);
    pkt(2, 16'h5A5A);
    expect_pkt(2, 16'h5A5A, 1'b1, 1'b0);
    opt(32'h00000000);
    pkt(2, 16'h5A5A);
    expect_pkt(2, 16'h5A5A, 1'b0, 1'b0);
    opt(32'hC0000000);
    pkt(1, 16'h3C3C);
    expect_pkt(1, 16'h3C3C, 1'b1, 1'b1);
    opt(32'h90000000);
    pkt(1, 16'h3C3C);
    repeat (10) @(posedge clk);
    chk({4'h0, 32'(u_idc_mem_sink.got.size())}, 36'h0, "mask miss");
    pktChanMatch <= 1'b0;
    pktMaskHit <= 1'b1;
    pkt(1, 16'h3C3C);
    expect_pkt(1, 16'h3C3C, 1'b0, 1'b1);
    opt(32'h40000000);
    pktChanMatch <= 1'b1;
    hold <= 1'b1;
    slow <= 1'b1;
    fork
      pkt(5, 16'h0F0F);
      begin
        repeat (20) @(posedge clk);
        chk({35'h0, rdyS}, 36'h0, "buffer full");
        hold <= 1'b0;
      end
    join
    expect_pkt(5, 16'h0F0F, 1'b1, 1'b0);
    end_of_test();
  end
endmodule
